// ===== tcc_channels.sv
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module tcc_channels (
  input logic clock,
  input logic rst_n,
  input tcc_pkg::tcc_apb_req_type apb_req,
  output tcc_pkg::tcc_apb_rsp_type apb_rsp,
  input tcc_pkg::tcc_timebase_type timebase,
  input logic [tcc_pkg::NUM_CH-1:0] pin_in,
  output logic [tcc_pkg::NUM_CH-1:0] pin_out,
  output logic [tcc_pkg::NUM_CH-1:0] pin_oe,
  output logic [tcc_pkg::NUM_CH-1:0] irq_req,
  output logic [tcc_pkg::NUM_CH-1:0] dma_req
);

  localparam int NCH = tcc_pkg::NUM_CH;
  localparam int CW = tcc_pkg::CNT_W;

  function automatic logic [2:0] pow2_mask(input logic [1:0] sel);
    pow2_mask = 3'((4'h1 << sel) - 4'h1);
  endfunction

  function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] ofs);
    word_hit = (addr == ofs);
  endfunction

  function automatic logic bank_hit(input logic [7:0] addr, input logic [7:0] base);
    bank_hit = (addr[7:4] == base[7:4]) && (addr[1:0] == 2'b00);
  endfunction

  logic rst_meta_reg;
  logic rst_sync_n_reg;
  logic [NCH-1:0] pin_meta_reg;
  logic [NCH-1:0] pin_sync_reg;
  logic [tcc_pkg::SMP_DIV_W-1:0] smp_div_reg;
  logic [NCH-1:0] filt_reg;
  logic [NCH-1:0] filt_prev_reg;
  logic [3:0] filt_cnt_reg [NCH];
  logic [2:0] psc_cnt_reg [NCH];
  tcc_pkg::tcc_ctl_type ctl_reg [NCH];
  logic [CW-1:0] preload_reg [NCH];
  logic [CW-1:0] shadow_reg [NCH];
  logic [NCH-1:0] copy_pend_reg;
  logic [NCH-1:0] flag_reg;
  logic [NCH-1:0] ovr_reg;
  logic [NCH-1:0] ref_reg;
  logic [CW-1:0] cnt_prev_reg;
  tcc_pkg::tcc_align_type align_reg;
  tcc_pkg::tcc_apb_rsp_type rsp_reg;

  logic [NCH-1:0] is_out;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  logic [NCH-1:0] sel_edge;
  logic [NCH-1:0] hw_capture;
  logic [NCH-1:0] sw_gen;
  logic [NCH-1:0] match_raw;
  logic [NCH-1:0] cap_evt;
  logic [NCH-1:0] cmp_evt;
  logic [NCH-1:0] flag_next;
  logic [NCH-1:0] ovr_next;
  logic [NCH-1:0] ctl_wr;
  logic [NCH-1:0] val_wr;
  logic [NCH-1:0] val_rd;
  logic flag_wr;
  logic align_wr;
  logic align_ok;
  logic access_done;
  logic setup_phase;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [7:0] addr;
  logic [31:0] wdata;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // APB decode
  assign addr = apb_req.paddr;
  assign wdata = apb_req.pwdata;
  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign access_done = apb_req.psel && apb_req.penable && rsp_reg.pready;
  assign flag_wr = access_done && apb_req.pwrite && word_hit(addr, tcc_pkg::OFS_FLAG);
  assign align_wr = access_done && apb_req.pwrite && word_hit(addr, tcc_pkg::OFS_ALIGN);

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ctl_wr[i] = access_done && apb_req.pwrite && bank_hit(addr, tcc_pkg::OFS_CTL_BASE)
                  && (addr[3:2] == 2'(i));
      val_wr[i] = access_done && apb_req.pwrite && bank_hit(addr, tcc_pkg::OFS_VAL_BASE)
                  && (addr[3:2] == 2'(i));
      val_rd[i] = access_done && !apb_req.pwrite && bank_hit(addr, tcc_pkg::OFS_VAL_BASE)
                  && (addr[3:2] == 2'(i));
      sw_gen[i] = access_done && apb_req.pwrite && word_hit(addr, tcc_pkg::OFS_EVGEN)
                  && wdata[i];
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (bank_hit(addr, tcc_pkg::OFS_CTL_BASE)) begin
      rd_data = {16'h0000, ctl_reg[addr[3:2]]};
    end else if (bank_hit(addr, tcc_pkg::OFS_VAL_BASE)) begin
      rd_data = {16'h0000, preload_reg[addr[3:2]]};
    end else if (word_hit(addr, tcc_pkg::OFS_FLAG)) begin
      rd_data[tcc_pkg::FLAG_EVT_LSB +: NCH] = flag_reg;
      rd_data[tcc_pkg::FLAG_OVR_LSB +: NCH] = ovr_reg;
    end else if (word_hit(addr, tcc_pkg::OFS_ALIGN)) begin
      rd_data[1:0] = align_reg;
    end else if (!word_hit(addr, tcc_pkg::OFS_EVGEN)) begin
      rd_ok = 1'b0;
    end
  end

  // Answer is prepared in the setup cycle so every transfer has zero wait states
  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      rsp_reg <= '0;
    end else if (setup_phase) begin
      rsp_reg.pready <= 1'b1;
      rsp_reg.pslverr <= !rd_ok;
      rsp_reg.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      rsp_reg <= '0;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      for (int i = 0; i < NCH; i++) begin
        ctl_reg[i] <= tcc_pkg::tcc_ctl_type'(tcc_pkg::CTL_RESET);
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (ctl_wr[i]) begin
          ctl_reg[i] <= tcc_pkg::tcc_ctl_type'(wdata[15:0]);
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      align_reg <= tcc_pkg::tcc_align_type'(tcc_pkg::ALIGN_RESET);
    end else if (align_wr) begin
      align_reg <= tcc_pkg::tcc_align_type'(wdata[1:0]);
    end
  end

  // Free-running divider that paces the filter sampling
  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      smp_div_reg <= '0;
    end else begin
      smp_div_reg <= smp_div_reg + 3'h1;
    end
  end

  // Field [3:2] sets the sample rate, [1:0] the run of equal samples needed
  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      filt_reg <= '0;
      filt_prev_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        filt_cnt_reg[i] <= 4'h0;
      end
    end else begin
      filt_prev_reg <= filt_reg;
      for (int i = 0; i < NCH; i++) begin
        if (ctl_reg[i].input_filter_field == 4'h0) begin
          filt_reg[i] <= pin_sync_reg[i];
          filt_cnt_reg[i] <= 4'h0;
        end else if ((smp_div_reg & pow2_mask(ctl_reg[i].input_filter_field[3:2])) == 3'h0) begin
          if (pin_sync_reg[i] == filt_reg[i]) begin
            filt_cnt_reg[i] <= 4'h0;
          end else if (filt_cnt_reg[i] + 4'h1 >=
                       ({1'b0, ctl_reg[i].input_filter_field[1:0], 1'b0}
                        + tcc_pkg::FILT_BASE_COUNT)) begin
            filt_reg[i] <= pin_sync_reg[i];
            filt_cnt_reg[i] <= 4'h0;
          end else begin
            filt_cnt_reg[i] <= filt_cnt_reg[i] + 4'h1;
          end
        end
      end
    end
  end

  // Edge, polarity and source selection; channels pair as 1-2 and 3-4
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      is_out[i] = ctl_reg[i].channel_direction_source_select == tcc_pkg::DIR_OUTPUT;
      rise[i] = filt_reg[i] && !filt_prev_reg[i];
      fall[i] = !filt_reg[i] && filt_prev_reg[i];
    end
    for (int i = 0; i < NCH; i++) begin
      unique case (ctl_reg[i].channel_direction_source_select)
        tcc_pkg::DIR_OWN: sel_edge[i] = ctl_reg[i].channel_polarity ? fall[i] : rise[i];
        tcc_pkg::DIR_NEIGHBOUR: sel_edge[i] = ctl_reg[i].channel_polarity ? fall[i ^ 1]
                                              : rise[i ^ 1];
        tcc_pkg::DIR_TRIGGER: sel_edge[i] = timebase.trigger_controller_input;
        tcc_pkg::DIR_OUTPUT: sel_edge[i] = 1'b0;
      endcase
      hw_capture[i] = ctl_reg[i].channel_output_or_capture_enable && !is_out[i] && sel_edge[i]
                      && (psc_cnt_reg[i] == pow2_mask(ctl_reg[i].capture_prescale));
    end
  end

  // Prescaler restarts whenever the channel is disabled or turned to output
  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      for (int i = 0; i < NCH; i++) begin
        psc_cnt_reg[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!ctl_reg[i].channel_output_or_capture_enable || is_out[i]) begin
          psc_cnt_reg[i] <= 3'h0;
        end else if (sel_edge[i]) begin
          if (psc_cnt_reg[i] == pow2_mask(ctl_reg[i].capture_prescale)) begin
            psc_cnt_reg[i] <= 3'h0;
          end else begin
            psc_cnt_reg[i] <= psc_cnt_reg[i] + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      cnt_prev_reg <= '0;
    end else begin
      cnt_prev_reg <= timebase.core_counter;
    end
  end

  // A match counts once per counter value, not for every clock it stays there
  always_comb begin
    unique case (align_reg)
      tcc_pkg::ALIGN_DOWN: align_ok = timebase.count_down;
      tcc_pkg::ALIGN_UP: align_ok = !timebase.count_down;
      tcc_pkg::ALIGN_EDGE, tcc_pkg::ALIGN_BOTH: align_ok = 1'b1;
    endcase
    for (int i = 0; i < NCH; i++) begin
      match_raw[i] = (timebase.core_counter == shadow_reg[i])
                     && (timebase.core_counter != cnt_prev_reg);
      cap_evt[i] = !is_out[i] && (hw_capture[i] || sw_gen[i]);
      cmp_evt[i] = is_out[i] && ((match_raw[i] && align_ok) || sw_gen[i]);
    end
  end

  // Capture goes to shadow first and reaches preload one clock later
  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      copy_pend_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        preload_reg[i] <= tcc_pkg::VAL_RESET;
        shadow_reg[i] <= tcc_pkg::VAL_RESET;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (is_out[i]) begin
          copy_pend_reg[i] <= 1'b0;
          if (val_wr[i]) begin
            preload_reg[i] <= wdata[CW-1:0];
          end
          if (!ctl_reg[i].compare_preload_enable) begin
            shadow_reg[i] <= val_wr[i] ? wdata[CW-1:0] : preload_reg[i];
          end else if (timebase.update_event) begin
            shadow_reg[i] <= preload_reg[i];
          end
        end else begin
          copy_pend_reg[i] <= cap_evt[i];
          if (cap_evt[i]) begin
            shadow_reg[i] <= timebase.core_counter;
          end
          if (copy_pend_reg[i]) begin
            preload_reg[i] <= shadow_reg[i];
          end else if (val_wr[i]) begin
            preload_reg[i] <= wdata[CW-1:0];
          end
        end
      end
    end
  end

  // A new event in the clearing cycle wins over the clear
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      flag_next[i] = cap_evt[i] || cmp_evt[i] || (flag_reg[i] && !val_rd[i]
                     && !(flag_wr && !wdata[tcc_pkg::FLAG_EVT_LSB + i]));
      ovr_next[i] = (cap_evt[i] && flag_reg[i])
                    || (ovr_reg[i] && !(flag_wr && !wdata[tcc_pkg::FLAG_OVR_LSB + i]));
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      flag_reg <= '0;
      ovr_reg <= '0;
    end else begin
      flag_reg <= flag_next;
      ovr_reg <= ovr_next;
    end
  end

  // Reference keeps running whatever the direction or enable, so switching modes is glitch-free
  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      ref_reg <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        unique case (ctl_reg[i].output_mode_field)
          tcc_pkg::MODE_FROZEN: ref_reg[i] <= ref_reg[i];
          tcc_pkg::MODE_MATCH_HIGH: ref_reg[i] <= ref_reg[i] || match_raw[i];
          tcc_pkg::MODE_MATCH_LOW: ref_reg[i] <= ref_reg[i] && !match_raw[i];
          tcc_pkg::MODE_TOGGLE: ref_reg[i] <= ref_reg[i] ^ match_raw[i];
          tcc_pkg::MODE_FORCE_LOW: ref_reg[i] <= 1'b0;
          tcc_pkg::MODE_FORCE_HIGH: ref_reg[i] <= 1'b1;
          tcc_pkg::MODE_PWM1: ref_reg[i] <= timebase.core_counter >= shadow_reg[i];
          tcc_pkg::MODE_PWM2: ref_reg[i] <= timebase.core_counter < shadow_reg[i];
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        pin_oe[i] <= ctl_reg[i].channel_output_or_capture_enable && is_out[i];
        pin_out[i] <= ctl_reg[i].channel_output_or_capture_enable && is_out[i]
                      && (ref_reg[i] ^ ctl_reg[i].channel_polarity);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      irq_req <= '0;
      dma_req <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        irq_req[i] <= flag_next[i] && ctl_reg[i].channel_irq_enable;
        dma_req[i] <= (cap_evt[i] || cmp_evt[i]) && ctl_reg[i].channel_dma_enable;
      end
    end
  end

  assign apb_rsp = rsp_reg;

endmodule // tcc_channels

// ===== tcc_pkg.sv
package tcc_pkg;

  localparam int NUM_CH = 4;
  localparam int CNT_W = 16;

  // Register byte addresses: four-word banks for control and value, one aligned 32-bit word each for the rest
  localparam logic [7:0] OFS_CTL_BASE = 8'h00;
  localparam logic [7:0] OFS_VAL_BASE = 8'h10;
  localparam logic [7:0] OFS_FLAG = 8'h20;
  localparam logic [7:0] OFS_EVGEN = 8'h24;
  localparam logic [7:0] OFS_ALIGN = 8'h28;

  // Flag register layout
  localparam int FLAG_EVT_LSB = 0;
  localparam int FLAG_OVR_LSB = 4;

  // Values after reset
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] VAL_RESET = 16'h0000;
  localparam logic [1:0] ALIGN_RESET = 2'h0;

  // Filter sample divider width and base count of equal samples
  localparam int SMP_DIV_W = 3;
  localparam logic [3:0] FILT_BASE_COUNT = 4'h2;

  typedef enum logic [1:0] {
    DIR_OUTPUT = 2'b00,
    DIR_OWN = 2'b01,
    DIR_NEIGHBOUR = 2'b10,
    DIR_TRIGGER = 2'b11
  } tcc_dir_type;

  typedef enum logic [2:0] {
    MODE_FROZEN = 3'b000,
    MODE_MATCH_HIGH = 3'b001,
    MODE_MATCH_LOW = 3'b010,
    MODE_TOGGLE = 3'b011,
    MODE_FORCE_LOW = 3'b100,
    MODE_FORCE_HIGH = 3'b101,
    MODE_PWM1 = 3'b110,
    MODE_PWM2 = 3'b111
  } tcc_mode_type;

  typedef enum logic [1:0] {
    ALIGN_EDGE = 2'b00,
    ALIGN_DOWN = 2'b01,
    ALIGN_UP = 2'b10,
    ALIGN_BOTH = 2'b11
  } tcc_align_type;

  typedef struct packed {
    logic channel_dma_enable;
    logic channel_irq_enable;
    logic channel_output_or_capture_enable;
    logic channel_polarity;
    logic compare_preload_enable;
    tcc_mode_type output_mode_field;
    logic [3:0] input_filter_field;
    logic [1:0] capture_prescale;
    tcc_dir_type channel_direction_source_select;
  } tcc_ctl_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tcc_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tcc_apb_rsp_type;

  typedef struct packed {
    logic [CNT_W-1:0] core_counter;
    logic update_event;
    logic count_down;
    logic trigger_controller_input;
  } tcc_timebase_type;

endpackage

// ===== tcc_chk.sv
`timescale 1ns/1ps
module tcc_chk (
  input logic clock,
  input logic rst_n,
  input tcc_pkg::tcc_apb_req_type apb_req,
  input tcc_pkg::tcc_apb_rsp_type apb_rsp,
  input logic [3:0] pin_out,
  input logic [3:0] pin_oe,
  input logic [3:0] irq_req,
  input logic [3:0] dma_req
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  tcc_pkg::tcc_ctl_type sh [4];
  logic [3:0] oe_exp;
  logic [3:0] ie;
  logic [3:0] de;
  logic acc;
  logic rd;
  assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign rd = acc && !apb_req.pwrite;
  // Mirror of the control words, taken from completed writes only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++)
        sh[i] <= '0;
    end else if (acc && apb_req.pwrite && apb_req.paddr[7:4] == 4'h0
                 && apb_req.paddr[1:0] == 2'h0) begin
      sh[apb_req.paddr[3:2]] <= tcc_pkg::tcc_ctl_type'(apb_req.pwdata[15:0]);
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      oe_exp[i] = sh[i].channel_direction_source_select == tcc_pkg::DIR_OUTPUT
        && sh[i].channel_output_or_capture_enable;
      ie[i] = sh[i].channel_irq_enable;
      de[i] = sh[i].channel_dma_enable;
    end
  end
  apb_ready_a: assert property (apb_req.psel && !apb_req.penable |=>
    apb_rsp.pready ##1 !apb_rsp.pready) else $error("pready not one access cycle");
  bad_addr_a: assert property (acc |-> apb_rsp.pslverr ==
    (apb_req.paddr > 8'h28 || apb_req.paddr[1:0] != 2'h0)) else $error("pslverr wrong");
  evgen_zero_a: assert property (rd && apb_req.paddr == tcc_pkg::OFS_EVGEN |->
    apb_rsp.prdata == 32'h0) else $error("event register read not zero");
  val_width_a: assert property (rd && apb_req.paddr[7:4] == 4'h1 |->
    apb_rsp.prdata[31:16] == 16'h0) else $error("value wider than counter");
  dma_pulse_a: assert property ((dma_req & $past(dma_req)) == 4'h0)
    else $error("dma request longer than one cycle");
  dma_gate_a: assert property ((dma_req & ~(de | $past(de))) == 4'h0)
    else $error("dma request while disabled");
  irq_gate_a: assert property (irq_req != 4'h0 |->
    (irq_req & ~(ie | $past(ie))) == 4'h0) else $error("interrupt while disabled");
  oe_match_a: assert property (pin_oe == $past(oe_exp))
    else $error("output enable does not follow direction");
  out_gate_a: assert property ((pin_out & ~pin_oe) == 4'h0)
    else $error("pin driven high while not output");
  cover property (dma_req[0]);
  cover property (irq_req[0]);
  cover property (acc && apb_rsp.pslverr);
endmodule // tcc_chk

bind tcc_channels tcc_chk u_chk (
  .clock,
  .rst_n,
  .apb_req,
  .apb_rsp,
  .pin_out,
  .pin_oe,
  .irq_req,
  .dma_req
);

// ===== tcc_pulse_src.sv
`timescale 1ns/1ps
module tcc_pulse_src (
  input logic clock,
  input logic rst_n,
  input logic go,
  input logic [15:0] period,
  input logic [15:0] high_time,
  input logic [7:0] pulses,
  input logic [3:0] pin_out,
  input logic [3:0] pin_oe,
  output logic [3:0] pin_in,
  output logic busy
);
  logic [15:0] phase_reg;
  logic [7:0] left_reg;
  logic level;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 16'h0000;
      left_reg <= 8'h00;
    end else if (go) begin
      phase_reg <= 16'h0000;
      left_reg <= pulses;
    end else if (busy) begin
      if (phase_reg == period - 16'h0001) begin
        phase_reg <= 16'h0000;
        left_reg <= left_reg - 8'h01;
      end else begin
        phase_reg <= phase_reg + 16'h0001;
      end
    end
  end
  assign busy = left_reg != 8'h00;
  // Pull-downs hold the pins low between bursts
  assign level = busy && phase_reg < high_time;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & {4{level}});
endmodule // tcc_pulse_src

// ===== tb_timer_capture_compare_channel.sv
`timescale 1ns/1ps
module tb_timer_capture_compare_channel;
  logic clock;
  logic rst_n;
  tcc_pkg::tcc_apb_req_type req;
  tcc_pkg::tcc_apb_rsp_type rsp;
  tcc_pkg::tcc_timebase_type tbs;
  logic [3:0] pin_in, pin_out, pin_oe, irq_req, dma_req;
  logic go, run, ug, busy, err;
  logic [15:0] per, hi, top, t_prev, t_last;
  logic [7:0] npulse;
  logic [31:0] q;
  int n_mismatch = 0;
  int checks = 0;
  int dcnt [4] = '{0, 0, 0, 0};

  tcc_channels uut (.clock, .rst_n, .apb_req(req), .apb_rsp(rsp), .timebase(tbs),
    .pin_in, .pin_out, .pin_oe, .irq_req, .dma_req);
  tcc_pulse_src src (.clock, .rst_n, .go, .period(per), .high_time(hi),
    .pulses(npulse), .pin_out, .pin_oe, .pin_in, .busy);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Time base stand-in plus request monitors
  always @(posedge clock) begin
    if (run)
      tbs.core_counter <= (tbs.core_counter == top) ? 16'h0 : tbs.core_counter + 16'h1;
    tbs.update_event <= ug || (run && tbs.core_counter == top);
    for (int i = 0; i < 4; i++)
      if (dma_req[i] === 1'b1) dcnt[i] <= dcnt[i] + 1;
    if (dma_req[0] === 1'b1) begin
      t_prev <= t_last;
      t_last <= tbs.core_counter;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    chk(32'(n), 32'h1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clock);
  endtask

  // Control word; bits = {dma, irq, enable, polarity, preload}
  function automatic logic [31:0] ctl(input logic [1:0] dir, input logic [1:0] psc,
    input logic [3:0] flt, input logic [2:0] md, input logic [4:0] bits);
    return {16'h0000, bits, md, flt, psc, dir};
  endfunction

  task automatic pulses(input logic [15:0] p, input logic [15:0] h, input logic [7:0] n);
    per <= p;
    hi <= h;
    npulse <= n;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    while (busy === 1'b1) @(posedge clock);
    repeat (12) @(posedge clock);
  endtask

  task automatic t_regs();
    xfer(1'b0, tcc_pkg::OFS_CTL_BASE, 32'h0);
    chk(q, {16'h0, tcc_pkg::CTL_RESET});
    xfer(1'b1, 8'h0c, 32'h0000ffff);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h0000ffff);
    xfer(1'b0, 8'h2c, 32'h0);
    chk(32'(err), 32'h1);
    xfer(1'b1, 8'h0c, 32'h0);
  endtask

  task automatic t_pwm_in();
    int d;
    logic [15:0] v;
    top <= 16'hffff;
    run <= 1'b1;
    xfer(1'b1, 8'h00, ctl(2'b01, 2'h0, 4'h0, 3'h0, 5'b11100));
    xfer(1'b1, 8'h04, ctl(2'b10, 2'h0, 4'h0, 3'h0, 5'b00110));
    d = dcnt[0];
    pulses(16'd50, 16'd20, 8'd2);
    chk(dcnt[0] - d, 2);
    v = t_last - t_prev;
    chk(32'(v), 32'd50);
    chk(32'(irq_req[1:0]), 32'h1);
    xfer(1'b0, tcc_pkg::OFS_FLAG, 32'h0);
    chk(q, 32'h33);
    xfer(1'b0, 8'h14, 32'h0);
    v = q[15:0];
    xfer(1'b0, 8'h10, 32'h0);
    v = v - q[15:0];
    chk(32'(v), 32'd20);
    xfer(1'b0, tcc_pkg::OFS_FLAG, 32'h0);
    chk(q, 32'h30);
    xfer(1'b1, tcc_pkg::OFS_FLAG, 32'h10);
    xfer(1'b0, tcc_pkg::OFS_FLAG, 32'h0);
    chk(q, 32'h10);
    xfer(1'b1, tcc_pkg::OFS_FLAG, 32'h0);
  endtask

  task automatic t_psc();
    int d;
    for (int p = 0; p < 4; p++) begin
      xfer(1'b1, 8'h08, ctl(2'b01, p[1:0], 4'h0, 3'h0, 5'b10100));
      d = dcnt[2];
      pulses(16'd12, 16'd6, 8'd16);
      chk(dcnt[2] - d, 16 >> p);
    end
    xfer(1'b1, 8'h08, ctl(2'b01, 2'h0, 4'h1, 3'h0, 5'b10100));
    d = dcnt[2];
    pulses(16'd20, 16'd2, 8'd4);
    chk(dcnt[2] - d, 0);
    pulses(16'd20, 16'd8, 8'd4);
    chk(dcnt[2] - d, 4);
  endtask

  task automatic t_swev();
    int d;
    xfer(1'b1, 8'h0c, ctl(2'b01, 2'h0, 4'h0, 3'h0, 5'b10000));
    d = dcnt[3];
    pulses(16'd12, 16'd6, 8'd2);
    chk(dcnt[3] - d, 0);
    xfer(1'b1, tcc_pkg::OFS_EVGEN, 32'h8);
    xfer(1'b1, tcc_pkg::OFS_EVGEN, 32'h8);
    xfer(1'b0, tcc_pkg::OFS_FLAG, 32'h0);
    chk(q & 32'h88, 32'h88);
    chk(dcnt[3] - d, 2);
    xfer(1'b1, tcc_pkg::OFS_FLAG, 32'h0);
    // Trigger source: one pulse on the time base input gives one capture
    xfer(1'b1, 8'h0c, ctl(2'b11, 2'h0, 4'h0, 3'h0, 5'b10100));
    d = dcnt[3];
    tbs.trigger_controller_input <= 1'b1;
    @(posedge clock);
    tbs.trigger_controller_input <= 1'b0;
    repeat (4) @(posedge clock);
    chk(dcnt[3] - d, 1);
  endtask

  task automatic t_cmp();
    logic [2:0] md [8] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h3, 3'h6, 3'h1, 3'h2};
    int ex [8] = '{0, 200, 120, 80, 100, 80, 200, 0};
    int h;
    int d;
    for (int i = 1; i < 4; i++)
      xfer(1'b1, 8'(4 * i), 32'h0);
    run <= 1'b0;
    @(posedge clock);
    tbs.core_counter <= 16'h0;
    top <= 16'd99;
    run <= 1'b1;
    xfer(1'b1, 8'h10, 32'd40);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 8'h00, ctl(2'b00, 2'h0, 4'h0, md[i], {3'b101, i == 5, 1'b0}));
      repeat (120) @(posedge clock);
      h = 0;
      d = dcnt[0];
      repeat (200) begin
        @(posedge clock);
        if (pin_out[0] === 1'b1) h++;
      end
      chk(h, ex[i]);
      chk(dcnt[0] - d, 2);
    end
    for (int a = 1; a < 4; a++) begin
      xfer(1'b1, tcc_pkg::OFS_ALIGN, 32'(a));
      d = dcnt[0];
      repeat (200) @(posedge clock);
      chk(dcnt[0] - d, (a == 1) ? 0 : 2);
    end
    // Counting down: the down-count setting flags matches; only the up-count setting blocks them
    tbs.count_down <= 1'b1;
    xfer(1'b1, tcc_pkg::OFS_ALIGN, 32'h1);
    d = dcnt[0];
    repeat (200) @(posedge clock);
    chk(dcnt[0] - d, 2);
    tbs.count_down <= 1'b0;
    run <= 1'b0;
    @(posedge clock);
    tbs.core_counter <= 16'h0;
    xfer(1'b1, tcc_pkg::OFS_ALIGN, 32'h0);
    xfer(1'b1, 8'h00, ctl(2'b00, 2'h0, 4'h0, 3'h6, 5'b00100));
    xfer(1'b1, 8'h10, 32'h0);
    repeat (4) @(posedge clock);
    chk(32'(pin_out[0]), 32'h1);
    xfer(1'b1, 8'h00, ctl(2'b00, 2'h0, 4'h0, 3'h6, 5'b00101));
    xfer(1'b1, 8'h10, 32'd10);
    repeat (4) @(posedge clock);
    chk(32'(pin_out[0]), 32'h1);
    ug <= 1'b1;
    @(posedge clock);
    ug <= 1'b0;
    repeat (4) @(posedge clock);
    chk(32'(pin_out[0]), 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    req = '0;
    tbs = '0;
    {go, run, ug} = 3'b000;
    {per, hi, npulse} = '0;
    {top, t_prev, t_last} = {16'hffff, 32'h0};
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk(32'({pin_oe, irq_req, dma_req}), 32'h0);
    t_regs();
    t_pwm_in();
    t_psc();
    t_swev();
    t_cmp();
    give_verdict();
  end
endmodule // tb_timer_capture_compare_channel
